/* verilog/dvs_pkg.sv */
// constants for the dynamic voltage scaling control block
package dvs_pkg;
   localparam int CLK_PERIOD_PS = 4000;
   localparam int NUM_CH = 4;
   localparam int CODE_W = 5;
   localparam int TMR_W = 12;
   // register offsets
   localparam logic [7:0] ADDR_SHDN = 8'h02;
   localparam logic [7:0] ADDR_OUTPUT_ENABLE_REG = 8'h10;
   localparam logic [7:0] ADDR_OUTPUT_GOOD_STATUS = 8'h13;
   localparam logic [7:0] ADDR_VOLTAGE_CHANGE_CONTROL_REG = 8'h20;
   localparam logic [7:0] ADDR_INTERRUPT_CLEAR_REG = 8'h21;
   localparam logic [7:0] ADDR_B1_FIRST = 8'h23;
   localparam logic [7:0] ADDR_B1_SECOND = 8'h24;
   localparam logic [7:0] ADDR_RAMP = 8'h25;
   localparam logic [7:0] ADDR_B2_FIRST = 8'h26;
   localparam logic [7:0] ADDR_B2_SECOND = 8'h27;
   localparam logic [7:0] ADDR_B3_FIRST = 8'h29;
   localparam logic [7:0] ADDR_B3_SECOND = 8'h2a;
   localparam logic [7:0] ADDR_L2_FIRST = 8'h32;
   localparam logic [7:0] ADDR_L2_SECOND = 8'h33;
   // reset values
   localparam logic [7:0] RST_TARGET = 8'h19;
   localparam logic [7:0] RST_RAMP = 8'hff;
   localparam logic [7:0] RST_ZERO = 8'h00;
   // writable bits (for shdn the pin-driven bits, none writable), the rest read as zero
   localparam logic [7:0] WM_B1_FIRST = 8'hff;
   localparam logic [7:0] WM_BX_FIRST = 8'h3f;
   localparam logic [7:0] WM_L2_FIRST = 8'hbf;
   localparam logic [7:0] WM_BX_SECOND = 8'hff;
   localparam logic [7:0] WM_SHDN = 8'ha8;
   // field positions
   localparam int BIT_PG_MASK = 5;
   localparam int BIT_FREQ = 5;
   localparam int BIT_EDGE_LO = 6;
   localparam int BIT_L4_VSEL_LO = 5;
   localparam int BIT_L4_SRC = 7;
   localparam int BIT_OUTPUT_ENABLE_REG_L4 = 6;
   // ramp: one dac lsb is 12.5 mV, rates in uV per us
   localparam int STEP_UV = 12500;
   localparam int RATE_00_UVUS = 880;
   localparam int RATE_01_UVUS = 1750;
   localparam int RATE_10_UVUS = 3500;
   localparam int RATE_11_UVUS = 7000;
   // interval in ns first, then ps, so no product leaves 32 bits
   localparam int CYC_00 = (STEP_UV * 1000 / RATE_00_UVUS) * 1000 / CLK_PERIOD_PS;
   localparam int CYC_01 = (STEP_UV * 1000 / RATE_01_UVUS) * 1000 / CLK_PERIOD_PS;
   localparam int CYC_10 = (STEP_UV * 1000 / RATE_10_UVUS) * 1000 / CLK_PERIOD_PS;
   localparam int CYC_11 = (STEP_UV * 1000 / RATE_11_UVUS) * 1000 / CLK_PERIOD_PS;
endpackage : dvs_pkg

/* verilog/dvs_ctrl.sv */
// register file and reference dac slew control for dynamic voltage scaling
`timescale 1ns/1ps
module dvs_ctrl #(
   parameter bit BASE_VARIANT = 1'b1
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [7:0] cmd_addr,
   input wire logic cmd_wr,
   input wire logic [7:0] cmd_wdata,
   input wire logic cmd_rd,
   input wire logic cmd_sub_ack,
   output logic [7:0] cmd_rdata,
   input wire logic irq_event,
   output logic irq_n,
   input wire logic standby_select_pin,
   input wire logic ldo34_enable_pin,
   input wire logic [7:0] pg_status_pin,
   input wire logic [2:0] shutdown_pin,
   input wire logic pg_ok_in,
   output logic power_good_out,
   output logic [19:0] dac_codes,
   output logic [2:0] buck_freq_slow,
   output logic [1:0] buck_edge_rate,
   output logic [1:0] ldo4_vsel,
   output logic ldo4_enable
);
   import dvs_pkg::*;

   // slowest rate must fit the step timer, fastest must not round to zero
   if (CYC_00 >= (1 << TMR_W) || CYC_11 < 1) begin : g_bad_timer
      $error("ramp interval does not fit the step timer");
   end

   // channel order: 0 buck1, 1 buck2, 2 buck3, 3 ldo2
   function automatic int first_ch(input logic [7:0] a);
      case (a)
         ADDR_B1_FIRST: first_ch = 0;
         ADDR_B2_FIRST: first_ch = 1;
         ADDR_B3_FIRST: first_ch = 2;
         ADDR_L2_FIRST: first_ch = 3;
         default: first_ch = -1;
      endcase
   endfunction : first_ch

   function automatic int second_ch(input logic [7:0] a);
      case (a)
         ADDR_B1_SECOND: second_ch = 0;
         ADDR_B2_SECOND: second_ch = 1;
         ADDR_B3_SECOND: second_ch = 2;
         ADDR_L2_SECOND: second_ch = 3;
         default: second_ch = -1;
      endcase
   endfunction : second_ch

   function automatic logic [TMR_W-1:0] rate_cycles(input logic [1:0] code);
      case (code)
         2'b00: rate_cycles = TMR_W'(CYC_00);
         2'b01: rate_cycles = TMR_W'(CYC_01);
         2'b10: rate_cycles = TMR_W'(CYC_10);
         default: rate_cycles = TMR_W'(CYC_11);
      endcase
   endfunction : rate_cycles

   // pin synchronisers, no reset: the reset cycles flush them
   logic stby_m_q, stby_s_q, stby_prev_q;
   logic en34_m_q, en34_s_q;
   logic [7:0] pg_m_q, pg_s_q;
   logic [2:0] sd_m_q, sd_s_q;
   always_ff @(posedge ref_clk) begin
      stby_m_q <= standby_select_pin;
      stby_s_q <= stby_m_q;
      stby_prev_q <= stby_s_q;
      en34_m_q <= ldo34_enable_pin;
      en34_s_q <= en34_m_q;
      pg_m_q <= pg_status_pin;
      pg_s_q <= pg_m_q;
      sd_m_q <= shutdown_pin;
      sd_s_q <= sd_m_q;
   end

   // registers
   logic [7:0] first_q [NUM_CH];
   logic [7:0] second_q [NUM_CH];
   logic [7:0] ramp_q, output_enable_reg_q;
   logic [NUM_CH-1:0] sel_q, go_q;
   logic [CODE_W-1:0] dac_q [NUM_CH];
   logic [TMR_W-1:0] tmr_q [NUM_CH];
   logic irq_n_q, pg_q;
   logic [7:0] rdata_q;
   logic [2:0] freq_q;
   logic [1:0] edge_q, l4v_q;
   logic l4en_q;

   int wr_first;
   int wr_second;
   assign wr_first = cmd_wr ? first_ch(cmd_addr) : -1;
   assign wr_second = cmd_wr ? second_ch(cmd_addr) : -1;
   wire wr_voltage_change_control_reg = cmd_wr && (cmd_addr == ADDR_VOLTAGE_CHANGE_CONTROL_REG);
   wire wr_ramp = cmd_wr && (cmd_addr == ADDR_RAMP);
   wire wr_output_enable_reg = cmd_wr && (cmd_addr == ADDR_OUTPUT_ENABLE_REG);
   wire interrupt_clear_reg_ack = cmd_sub_ack && (cmd_addr == ADDR_INTERRUPT_CLEAR_REG);
   // standby edges re-arm every channel so the reference follows the pin
   wire stby_edge = stby_s_q ^ stby_prev_q;
   wire [7:0] l2_second_wm = BASE_VARIANT ? 8'hff : 8'h7f;

   logic [CODE_W-1:0] tgt [NUM_CH];
   logic [NUM_CH-1:0] at_tgt, slew_hold;
   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++) begin : g_ch
         assign tgt[g] = (stby_s_q || sel_q[g]) ? second_q[g][CODE_W-1:0]
                                                : first_q[g][CODE_W-1:0];
         assign at_tgt[g] = (dac_q[g] == tgt[g]);
         assign slew_hold[g] = go_q[g] && !first_q[g][BIT_PG_MASK];
         wire [1:0] rate_code = ramp_q[2*g +: 2];
         wire go_set = (wr_voltage_change_control_reg && cmd_wdata[2*g]) || stby_edge;

         always_ff @(posedge ref_clk) begin
            if (rst) begin
               first_q[g] <= RST_TARGET;
            end else if (wr_first == g) begin
               first_q[g] <= cmd_wdata & ((g == 0) ? WM_B1_FIRST
                              : (g == 3) ? WM_L2_FIRST : WM_BX_FIRST);
            end
         end

         always_ff @(posedge ref_clk) begin
            if (rst) begin
               second_q[g] <= RST_TARGET;
            end else if (wr_second == g) begin
               second_q[g] <= cmd_wdata & ((g == 3) ? l2_second_wm : WM_BX_SECOND);
            end
         end

         always_ff @(posedge ref_clk) begin
            if (rst) begin
               sel_q[g] <= 1'b0;
            end else if (wr_voltage_change_control_reg) begin
               sel_q[g] <= cmd_wdata[2*g+1];
            end
         end

         // a go write in the same cycle as completion wins
         always_ff @(posedge ref_clk) begin
            if (rst) begin
               go_q[g] <= 1'b0;
            end else if (go_set) begin
               go_q[g] <= 1'b1;
            end else if (at_tgt[g]) begin
               go_q[g] <= 1'b0;
            end
         end

         // timer reload on start so the first step waits a full interval
         always_ff @(posedge ref_clk) begin
            if (rst) begin
               dac_q[g] <= RST_TARGET[CODE_W-1:0];
               tmr_q[g] <= '0;
            end else if (!go_q[g] || at_tgt[g]) begin
               tmr_q[g] <= rate_cycles(rate_code) - TMR_W'(1);
            end else if (tmr_q[g] != '0) begin
               tmr_q[g] <= tmr_q[g] - TMR_W'(1);
            end else begin
               tmr_q[g] <= rate_cycles(rate_code) - TMR_W'(1);
               dac_q[g] <= (dac_q[g] < tgt[g]) ? dac_q[g] + CODE_W'(1)
                                               : dac_q[g] - CODE_W'(1);
            end
         end

         assign dac_codes[CODE_W*g +: CODE_W] = dac_q[g];
      end
   endgenerate

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ramp_q <= RST_RAMP;
         output_enable_reg_q <= RST_ZERO;
      end else begin
         if (wr_ramp) begin
            ramp_q <= cmd_wdata;
         end
         if (wr_output_enable_reg) begin
            output_enable_reg_q <= cmd_wdata;
         end
      end
   end

   // the clear write carries no data path at all
   // an event in the clearing cycle keeps the pin low
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         irq_n_q <= 1'b1;
      end else if (irq_event) begin
         irq_n_q <= 1'b0;
      end else if (interrupt_clear_reg_ack) begin
         irq_n_q <= 1'b1;
      end
   end

   // read data is registered so the serial shifter sees a steady byte
   logic [7:0] rd_mux;
   always_comb begin
      rd_mux = 8'h00;
      case (cmd_addr)
         ADDR_SHDN: rd_mux = {sd_s_q[2], 1'b0, sd_s_q[1], 1'b0, sd_s_q[0], 3'b000};
         ADDR_OUTPUT_GOOD_STATUS: rd_mux = pg_s_q;
         ADDR_OUTPUT_ENABLE_REG: rd_mux = output_enable_reg_q;
         ADDR_VOLTAGE_CHANGE_CONTROL_REG: rd_mux = {sel_q[3], go_q[3], sel_q[2], go_q[2],
                              sel_q[1], go_q[1], sel_q[0], go_q[0]};
         ADDR_RAMP: rd_mux = ramp_q;
         ADDR_B1_FIRST: rd_mux = first_q[0];
         ADDR_B2_FIRST: rd_mux = first_q[1];
         ADDR_B3_FIRST: rd_mux = first_q[2];
         ADDR_L2_FIRST: rd_mux = first_q[3];
         ADDR_B1_SECOND: rd_mux = second_q[0];
         ADDR_B2_SECOND: rd_mux = second_q[1];
         ADDR_B3_SECOND: rd_mux = second_q[2];
         ADDR_L2_SECOND: rd_mux = second_q[3];
         default: rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rdata_q <= 8'h00;
      end else if (cmd_rd) begin
         rdata_q <= rd_mux;
      end
   end

   // output stage, each output straight from a flop
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pg_q <= 1'b0;
         freq_q <= 3'b000;
         edge_q <= 2'b00;
         l4v_q <= 2'b00;
         l4en_q <= 1'b0;
      end else begin
         pg_q <= pg_ok_in && (slew_hold == '0);
         freq_q <= {second_q[2][BIT_FREQ], second_q[1][BIT_FREQ],
                    second_q[0][BIT_FREQ]};
         edge_q <= first_q[0][BIT_EDGE_LO +: 2];
         l4v_q <= second_q[3][BIT_L4_VSEL_LO +: 2];
         l4en_q <= (BASE_VARIANT && second_q[3][BIT_L4_SRC]) ? output_enable_reg_q[BIT_OUTPUT_ENABLE_REG_L4]
                                                             : en34_s_q;
      end
   end

   assign cmd_rdata = rdata_q;
   assign irq_n = irq_n_q;
   assign power_good_out = pg_q;
   assign buck_freq_slow = freq_q;
   assign buck_edge_rate = edge_q;
   assign ldo4_vsel = l4v_q;
   assign ldo4_enable = l4en_q;

   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   a_go_self_clear: assert property (
      go_q[0] && at_tgt[0] && !wr_voltage_change_control_reg && !stby_edge |=> !go_q[0])
      else $error("go bit not cleared at slew end");
   a_go_start: assert property (wr_voltage_change_control_reg && cmd_wdata[0] |=> go_q[0])
      else $error("go write did not start a slew");
   a_irq_release: assert property (interrupt_clear_reg_ack && !irq_event |=> irq_n)
      else $error("interrupt not released on clear ack");
   a_clear_no_store: assert property (
      cmd_wr && cmd_addr == ADDR_INTERRUPT_CLEAR_REG
      |=> $stable(sel_q) && $stable(ramp_q) && $stable(output_enable_reg_q))
      else $error("clear write changed stored state");
   a_standby_second: assert property (stby_s_q |-> tgt[1] == second_q[1][4:0])
      else $error("standby did not force second target");
   a_sel_low_first: assert property (
      !stby_s_q && !sel_q[2] |-> tgt[2] == first_q[2][4:0])
      else $error("select low did not pick first target");
   a_pg_forced_low: assert property (
      go_q[3] && !first_q[3][BIT_PG_MASK] |=> !power_good_out)
      else $error("power good not held low while slewing");
   a_pg_released: assert property (pg_ok_in && slew_hold == '0 |=> power_good_out)
      else $error("power good held low with no unmasked slew");
   a_idle_no_move: assert property (!go_q[0] |=> $stable(dac_q[0]))
      else $error("dac moved without a go");
   a_step_spacing: assert property (
      ramp_q[1:0] == 2'b11 && $changed(dac_q[0]) && !wr_ramp |=> $stable(dac_q[0]) [*8])
      else $error("dac stepped faster than the ramp rate");
   a_single_step: assert property ($changed(dac_q[0]) |->
      (dac_q[0] - $past(dac_q[0]) == 5'd1) || ($past(dac_q[0]) - dac_q[0] == 5'd1))
      else $error("dac step larger than one code");
   a_hold_at_target: assert property (at_tgt[3] |=> $stable(dac_q[3]))
      else $error("dac moved while at its target");
   a_edge_follow: assert property (
      buck_edge_rate == $past(first_q[0][BIT_EDGE_LO +: 2]))
      else $error("edge rate bits not followed");
   a_freq_follow: assert property (
      buck_freq_slow == $past({second_q[2][BIT_FREQ], second_q[1][BIT_FREQ],
      second_q[0][BIT_FREQ]}))
      else $error("switching frequency bits not followed");
   a_status_read: assert property (
      cmd_rd && cmd_addr == ADDR_OUTPUT_GOOD_STATUS |=> cmd_rdata == $past(pg_s_q))
      else $error("good status read mismatch");
   a_shdn_unused: assert property (
      cmd_rd && cmd_addr == ADDR_SHDN |=> (cmd_rdata & ~WM_SHDN) == 8'h00)
      else $error("unused shutdown bits read as one");
   a_ldo4_vsel: assert property (
      ldo4_vsel == $past(second_q[3][BIT_L4_VSEL_LO +: 2]))
      else $error("ldo4 voltage select not followed");
   a_ldo4_source: assert property (
      ldo4_enable == $past((BASE_VARIANT && second_q[3][BIT_L4_SRC]) ? output_enable_reg_q[BIT_OUTPUT_ENABLE_REG_L4]
      : en34_s_q))
      else $error("ldo4 enable source wrong");

   c_slew_done: cover property (go_q[0] ##1 !go_q[0]);
   c_irq_cleared: cover property (!irq_n ##1 interrupt_clear_reg_ack ##1 irq_n);
   c_standby_slew: cover property (stby_edge ##1 go_q[3]);
   c_masked_slew: cover property (go_q[0] && first_q[0][BIT_PG_MASK] && power_good_out);
   c_step_down: cover property (go_q[0] && !sel_q[0] && $changed(dac_q[0]));
endmodule : dvs_ctrl

/* tb/dvs_host.sv */
// host-side model driving the serial front end register strobes
`timescale 1ns/1ps
module dvs_host (
   input wire logic ref_clk,
   output logic [7:0] cmd_addr,
   output logic cmd_wr,
   output logic [7:0] cmd_wdata,
   output logic cmd_rd,
   output logic cmd_sub_ack,
   input wire logic [7:0] cmd_rdata
);
   import dvs_pkg::*;
   initial begin
      cmd_addr = 8'h00;
      cmd_wr = 1'b0;
      cmd_wdata = 8'h00;
      cmd_rd = 1'b0;
      cmd_sub_ack = 1'b0;
   end
   // one byte per access, the sub-address is acked with every access
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      cmd_addr = a;
      cmd_wdata = d;
      cmd_wr = 1'b1;
      cmd_sub_ack = 1'b1;
      @(negedge ref_clk);
      cmd_wr = 1'b0;
      cmd_sub_ack = 1'b0;
      cmd_wdata = ~d; // released data never shows the last byte
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge ref_clk);
      cmd_addr = a;
      cmd_rd = 1'b1;
      cmd_sub_ack = 1'b1;
      @(negedge ref_clk);
      cmd_rd = 1'b0;
      cmd_sub_ack = 1'b0;
      d = cmd_rdata;
   endtask : rd
endmodule : dvs_host

/* tb/testbench.sv */
// self-checking bench for the voltage scaling control block
`timescale 1ns/1ps
module testbench;
   import dvs_pkg::*;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] cmd_addr, cmd_wdata, cmd_rdata, pg_status_pin, rv;
   logic cmd_wr, cmd_rd, cmd_sub_ack, irq_n, power_good_out, ldo4_enable;
   logic irq_event = 1'b0;
   logic standby_select_pin = 1'b0;
   logic ldo34_enable_pin = 1'b0;
   logic pg_ok_in = 1'b1;
   logic [2:0] shutdown_pin = 3'b000;
   logic [19:0] dac_codes;
   logic [2:0] buck_freq_slow;
   logic [1:0] buck_edge_rate, ldo4_vsel;
   int n_mismatch = 0;
   int n_compared = 0;
   always #2 ref_clk = ~ref_clk;
   initial pg_status_pin = 8'h00;
   dvs_host u_host (.ref_clk(ref_clk), .cmd_addr(cmd_addr), .cmd_wr(cmd_wr),
      .cmd_wdata(cmd_wdata), .cmd_rd(cmd_rd), .cmd_sub_ack(cmd_sub_ack), .cmd_rdata(cmd_rdata));
   dvs_ctrl u_dvs_ctrl (.ref_clk(ref_clk), .rst(rst), .cmd_addr(cmd_addr), .cmd_wr(cmd_wr),
      .cmd_wdata(cmd_wdata), .cmd_rd(cmd_rd), .cmd_sub_ack(cmd_sub_ack),
      .cmd_rdata(cmd_rdata), .irq_event(irq_event), .irq_n(irq_n),
      .standby_select_pin(standby_select_pin), .ldo34_enable_pin(ldo34_enable_pin),
      .pg_status_pin(pg_status_pin), .shutdown_pin(shutdown_pin), .pg_ok_in(pg_ok_in),
      .power_good_out(power_good_out), .dac_codes(dac_codes),
      .buck_freq_slow(buck_freq_slow), .buck_edge_rate(buck_edge_rate),
      .ldo4_vsel(ldo4_vsel), .ldo4_enable(ldo4_enable));
   task automatic chk(input logic [19:0] got, input logic [19:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic waitn(input int n);
      repeat (n) @(negedge ref_clk);
   endtask : waitn
   task automatic results;
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : results
   task automatic t_reset;
      chk(dac_codes, {4{5'h19}}, "reset codes");
      u_host.rd(ADDR_L2_SECOND, rv);
      chk(rv, 8'h19, "ldo2 second reset");
      u_host.rd(ADDR_RAMP, rv);
      chk(rv, 8'hff, "ramp reset");
   endtask : t_reset
   task automatic t_status;
      pg_status_pin = 8'ha5;
      shutdown_pin = 3'b101;
      waitn(5);
      u_host.rd(ADDR_OUTPUT_GOOD_STATUS, rv);
      chk(rv, 8'ha5, "good status");
      u_host.wr(ADDR_SHDN, 8'hff);
      u_host.rd(ADDR_SHDN, rv);
      chk(rv, 8'h88, "shutdown cause");
   endtask : t_status
   task automatic t_irq;
      irq_event = 1'b1;
      waitn(1);
      irq_event = 1'b0;
      waitn(1);
      chk(irq_n, 1'b0, "irq raised");
      u_host.wr(ADDR_INTERRUPT_CLEAR_REG, 8'hff);
      waitn(1);
      chk(irq_n, 1'b1, "irq cleared");
      u_host.rd(ADDR_VOLTAGE_CHANGE_CONTROL_REG, rv);
      chk(rv, 8'h00, "clear data dropped");
      u_host.rd(ADDR_RAMP, rv);
      chk(rv, 8'hff, "clear data not stored");
   endtask : t_irq
   task automatic t_cfg;
      ldo34_enable_pin = 1'b1;
      waitn(4);
      chk(ldo4_enable, 1'b1, "ldo4 pin source");
      u_host.wr(ADDR_L2_SECOND, 8'hd9);
      waitn(2);
      chk(ldo4_vsel, 2'b10, "ldo4 vsel");
      chk(ldo4_enable, 1'b0, "ldo4 reg source");
      u_host.wr(ADDR_OUTPUT_ENABLE_REG, 8'h40);
      waitn(2);
      chk(ldo4_enable, 1'b1, "ldo4 reg enable");
      u_host.wr(ADDR_B1_FIRST, 8'hd9);
      u_host.wr(ADDR_B2_FIRST, 8'hd9);
      u_host.wr(ADDR_B2_SECOND, 8'h39);
      u_host.rd(ADDR_B2_FIRST, rv);
      chk(rv, 8'h19, "edge bits only on buck1");
      chk(buck_edge_rate, 2'b11, "edge rate");
      chk(buck_freq_slow, 3'b010, "buck2 slow clock");
   endtask : t_cfg
   // rate 11 steps every 446 cycles, rate 10 every 892
   task automatic t_slew;
      u_host.wr(ADDR_B1_SECOND, 8'h1b);
      u_host.wr(ADDR_VOLTAGE_CHANGE_CONTROL_REG, 8'h02);
      waitn(600);
      chk(dac_codes[4:0], 5'h19, "no slew without go");
      u_host.wr(ADDR_VOLTAGE_CHANGE_CONTROL_REG, 8'h03);
      waitn(3);
      chk(power_good_out, 1'b0, "good forced low");
      waitn(597);
      chk(dac_codes[4:0], 5'h1a, "one step up");
      chk(dac_codes[19:5], {3{5'h19}}, "other channels idle");
      waitn(400);
      chk(dac_codes[4:0], 5'h1b, "second target");
      chk(power_good_out, 1'b1, "good released");
      u_host.rd(ADDR_VOLTAGE_CHANGE_CONTROL_REG, rv);
      chk(rv, 8'h02, "go self clear");
      u_host.wr(ADDR_RAMP, 8'hfe);
      u_host.wr(ADDR_VOLTAGE_CHANGE_CONTROL_REG, 8'h01);
      waitn(600);
      chk(dac_codes[4:0], 5'h1b, "slower rate holds");
      waitn(700);
      chk(dac_codes[4:0], 5'h1a, "one step down");
      waitn(600);
      chk(dac_codes[4:0], 5'h19, "first target");
      u_host.rd(ADDR_VOLTAGE_CHANGE_CONTROL_REG, rv);
      chk(rv, 8'h00, "go clear after down");
   endtask : t_slew
   // buck1 masked here, so its slew must leave power good high
   task automatic t_standby;
      u_host.wr(ADDR_RAMP, 8'hff);
      u_host.wr(ADDR_B1_FIRST, 8'hf9);
      standby_select_pin = 1'b1;
      waitn(20);
      chk(power_good_out, 1'b1, "masked slew keeps good");
      waitn(980);
      chk(dac_codes[4:0], 5'h1b, "standby forces second");
      standby_select_pin = 1'b0;
      waitn(1000);
      chk(dac_codes[4:0], 5'h19, "back to first");
   endtask : t_standby
   initial begin
      waitn(3);
      rst = 1'b0;
      waitn(1);
      t_reset();
      t_status();
      t_irq();
      t_cfg();
      t_slew();
      t_standby();
      results();
   end
   // whole run is near 5600 cycles, so 30000 means a hang
   initial begin
      repeat (30000) @(posedge ref_clk);
      n_mismatch++;
      results();
   end
endmodule : testbench
